// ==== inc/adsq_pkg.sv ====
// Shared constants and helpers of the converter sequencer
package adsq_pkg;
  localparam logic [7:0] OFS_CONTROL_ONE     = 8'h00;
  localparam logic [7:0] OFS_SEQUENCE_CONFIG = 8'h04;
  localparam logic [7:0] OFS_EXTRA_CONFIG    = 8'h08;
  localparam logic [7:0] OFS_INPUT_ENABLE    = 8'h0C;
  localparam logic [7:0] OFS_RESULT_LOW      = 8'h10;
  localparam logic [7:0] OFS_RESULT_HIGH     = 8'h14;

  localparam int CTL_EOC_BIT   = 7;
  localparam int CTL_START_BIT = 6;
  localparam int CTL_SEL_LSB   = 4;
  localparam int CFG_REF_LSB   = 6;
  localparam int CFG_DEC_LSB   = 4;
  localparam int CFG_CH_LSB    = 0;
  localparam int RES_LOW_LSB   = 2;

  localparam logic [1:0] START_SEL_RST    = 2'h3;
  localparam logic [7:0] CFG_RST          = 8'h00;
  localparam logic [7:0] INPUT_ENABLE_RST = 8'h00;

  localparam logic [1:0] SEL_EXT_PIN    = 2'h0;
  localparam logic [1:0] SEL_FULL_SPEED = 2'h1;
  localparam logic [1:0] SEL_TIMER      = 2'h2;
  localparam logic [1:0] SEL_SOFTWARE   = 2'h3;

  localparam logic [2:0] CLK_DIV_LAST  = 3'h5;
  localparam logic [2:0] CLK_DIV_HALF  = 3'h3;
  localparam logic [9:0] SETTLE_CYCLES = 10'h010;

  localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
  localparam logic [3:0] CH_GROUP_LAST = 4'hC;
  localparam logic [13:0] RES_MAX     = 14'h1FFF;
  localparam logic [13:0] RES_MIN     = 14'h2000;

  localparam logic [1:0] DEC_RATE_64  = 2'h0;
  localparam logic [1:0] DEC_RATE_128 = 2'h1;
  localparam logic [1:0] DEC_RATE_256 = 2'h2;

  // Filter length in converter clocks for a decimation select
  function automatic logic [9:0] rate_cycles(input logic [1:0] dec);
    if (dec == DEC_RATE_64) rate_cycles = 10'h040;
    else if (dec == DEC_RATE_128) rate_cycles = 10'h080;
    else if (dec == DEC_RATE_256) rate_cycles = 10'h100;
    else rate_cycles = 10'h200;
  endfunction

  // Left shift that brings a filter sum to the 14-bit full scale
  function automatic logic [2:0] rate_shift(input logic [1:0] dec);
    rate_shift = 3'h7 - {1'b0, dec};
  endfunction
endpackage

// ==== hdl/adsq_clkdiv.sv ====
// Divide-by-six converter clock and its tick
module adsq_clkdiv import adsq_pkg::*; (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      conv_clk,
  output logic      conv_tick
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       clk;
    logic       tick;
  } adsq_div_t;

  // Reset sits at the wrap point so the first high phase after reset is full length
  localparam adsq_div_t DIV_RST = '{cnt: CLK_DIV_LAST, default: '0};

  adsq_div_t s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = (s_q.cnt == CLK_DIV_LAST);
    s_d.cnt  = s_d.tick ? 3'h0 : s_q.cnt + 3'h1;
    s_d.clk  = (s_d.cnt < CLK_DIV_HALF);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign conv_clk  = s_q.clk;
  assign conv_tick = s_q.tick;
endmodule

// ==== hdl/adsq_conv.sv ====
// One conversion: settling, modulator decimation and result scaling
module adsq_conv import adsq_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        conv_tick,
  input  wire logic        start,
  input  wire logic [1:0]  dec_sel,
  input  wire logic        single_ended,
  input  wire logic        mod_bit,
  output logic             busy,
  output logic             done,
  output logic [13:0]      result
);
  typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_SETTLE = 2'b01, CV_FILTER = 2'b10} adsq_cv_t;
  typedef struct packed {
    adsq_cv_t    state;
    logic [9:0]  cnt;
    logic [9:0]  ones;
    logic [1:0]  dec;
    logic        se;
    logic        done;
    logic [13:0] res;
  } adsq_conv_t;

  localparam adsq_conv_t CONV_RST = '{state: CV_IDLE, default: '0};

  adsq_conv_t s_q, s_d;
  logic [9:0]         ones_n;
  logic signed [11:0] diff;
  logic signed [19:0] scaled;

  always_comb begin
    s_d    = s_q;
    s_d.done = 1'b0;
    ones_n = s_q.ones + {9'h000, mod_bit};
    diff   = $signed({1'b0, ones_n, 1'b0}) - $signed({2'b00, rate_cycles(s_q.dec)});
    scaled = 20'(diff) <<< rate_shift(s_q.dec);
    case (s_q.state)
      CV_IDLE: begin
        if (start) begin
          s_d.state = CV_SETTLE;
          s_d.cnt   = 10'h000;
          s_d.dec   = dec_sel;
          s_d.se    = single_ended;
        end
      end
      CV_SETTLE: begin
        if (conv_tick) begin
          s_d.cnt = s_q.cnt + 10'h001;
          if (s_q.cnt == SETTLE_CYCLES - 10'h001) begin
            s_d.state = CV_FILTER;
            s_d.cnt   = 10'h000;
            s_d.ones  = 10'h000;
          end
        end
      end
      CV_FILTER: begin
        if (conv_tick) begin
          s_d.cnt  = s_q.cnt + 10'h001;
          s_d.ones = ones_n;
          if (s_q.cnt == rate_cycles(s_q.dec) - 10'h001) begin
            s_d.state = CV_IDLE;
            s_d.done  = 1'b1;
            // Two's complement, clipped to the 14-bit range
            if (s_q.se && scaled < 0) s_d.res = 14'h0000;
            else if (scaled > $signed({6'h00, RES_MAX})) s_d.res = RES_MAX;
            else if (scaled < -$signed({6'h00, RES_MIN})) s_d.res = RES_MIN;
            else s_d.res = scaled[13:0];
          end
        end
      end
      default: s_d.state = CV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= CONV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy   = (s_q.state != CV_IDLE);
  assign done   = s_q.done;
  assign result = s_q.res;
endmodule

// ==== hdl/adsq_sequencer.sv ====
// Converter sequencer: registers, start logic, channel walk, DMA and interrupt
// Notes on behaviour
// - Last channel below 8: sequence converts channels 0 up to it.
// - Channels 0-7 single, 8-11 pairs, 12-15 ground, reference, temperature, supply.
// - Last channel 8-12 starts at 8; above 12 converts that one only.
// - A pending extra conversion runs as soon as the sequence finishes.
// - Writing the extra configuration launches it; fields coded as sequence config.
// - Disabled inputs are skipped in a sequence; pairs need both pins enabled.
// - Done flag set at conversion end, cleared by reading result high byte.
// - Software start needs select 11 and idle; bit clears when sequence ends.
// - Select picks pin edge, previous end, timer compare or software start.
// - Results are two's complement, 8191 to -8192 at full scale.
// - Single-ended inputs give non-negative results only.
// - Last-channel read gives last converted, plus one when written below 12.
// - Converter clock is the system clock divided by six.
// - Filter takes as many converter clocks as the decimation rate.
// - Every conversion first waits 16 converter clocks for settling.
// - Extra conversion end requests an interrupt; sequence ends do not.
// - Sequence conversion end gives a DMA trigger; extra conversion none.
// - Channels 0-7 each have their own DMA trigger on new sample.
// - Any sequence conversion also pulses the any-channel DMA trigger.
// - Decimation select sets result resolution from 6 to 9 bits.
// - Low byte holds result 5:0 in bits 7:2; high byte holds 13:6.
module adsq_sequencer import adsq_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        external_trigger_pin,
  input  wire logic        timer_compare_event,
  input  wire logic        modulator_bit,
  output logic             converter_clk,
  output logic [3:0]       mux_channel,
  output logic [1:0]       mux_reference,
  output logic [7:0]       per_channel_dma_trigger,
  output logic             any_channel_dma_trigger,
  output logic             conversion_irq
);
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_SEQ = 2'b01, SQ_EXTRA = 2'b10} adsq_sq_t;
  typedef struct packed {
    adsq_sq_t    state;
    logic        ack;
    logic [7:0]  dat;
    logic        trig_s1;
    logic        trig_s2;
    logic        trig_s3;
    logic        mod_s1;
    logic        mod_s2;
    logic        eoc;
    logic        st;
    logic [1:0]  sel;
    logic [1:0]  seq_ref;
    logic [1:0]  seq_dec;
    logic [3:0]  sch_wr;
    logic [3:0]  sch_rd;
    logic [1:0]  x_ref;
    logic [1:0]  x_dec;
    logic [3:0]  x_ch;
    logic        x_pend;
    logic [7:0]  ain_en;
    logic [13:0] res;
    logic [3:0]  cur_ch;
    logic        go;
    logic [1:0]  go_dec;
    logic [7:0]  dma_ch;
    logic        dma_any;
    logic        irq;
  } adsq_seq_t;

  localparam adsq_seq_t SEQ_RST = '{state: SQ_IDLE, sel: START_SEL_RST,
                                    ain_en: INPUT_ENABLE_RST, default: '0};

  adsq_seq_t s_q, s_d;
  logic        tick;
  logic        cv_busy;
  logic        cv_done;
  logic [13:0] cv_res;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  wdat;
  logic        trigger;
  logic [4:0]  pick;

  ////////////////////////////////////////////////////////////////////////////
  // Channel helpers

  // Pairs need both pins; ground and internal sources always convert
  function automatic logic ch_enabled(input logic [3:0] ch, input logic [7:0] en);
    if (ch < CH_FIRST_DIFF) ch_enabled = en[ch[2:0]];
    else if (ch < CH_GROUP_LAST) ch_enabled = &en[{ch[1:0], 1'b0} +: 2];
    else ch_enabled = 1'b1;
  endfunction

  // First enabled channel at or above 'from' and up to 'last'; bit 4 flags a hit
  function automatic logic [4:0] next_ch(input logic [4:0] from, input logic [3:0] last,
                                         input logic [7:0] en);
    next_ch = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (!next_ch[4] && 5'(i) >= from && 4'(i) <= last && ch_enabled(4'(i), en)) begin
        next_ch = {1'b1, 4'(i)};
      end
    end
  endfunction

  // Where a sequence begins for a given last-channel setting
  function automatic logic [4:0] seq_first(input logic [3:0] last);
    if (last < CH_FIRST_DIFF) seq_first = 5'h00;
    else if (last <= CH_GROUP_LAST) seq_first = {1'b0, CH_FIRST_DIFF};
    else seq_first = {1'b0, last};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Converter core

  adsq_clkdiv u_clkdiv (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .conv_clk  (converter_clk),
    .conv_tick (tick)
  );

  adsq_conv u_conv (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .conv_tick    (tick),
    .start        (s_q.go),
    .dec_sel      (s_q.go_dec),
    .single_ended (s_q.cur_ch < CH_FIRST_DIFF),
    .mod_bit      (s_q.mod_s2),
    .busy         (cv_busy),
    .done         (cv_done),
    .result       (cv_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and next state

  // Writes and read side effects land on the edge where the master sees ack
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && s_q.ack && wb_we_i && wb_sel_i[0];
  assign bus_rd  = bus_req && s_q.ack && !wb_we_i;
  assign wdat    = wb_dat_i[7:0];

  always_comb begin
    s_d         = s_q;
    s_d.go      = 1'b0;
    s_d.dma_ch  = 8'h00;
    s_d.dma_any = 1'b0;
    s_d.irq     = 1'b0;
    pick        = 5'h00;
    s_d.trig_s1 = external_trigger_pin;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_s3 = s_q.trig_s2;
    s_d.mod_s1  = modulator_bit;
    s_d.mod_s2  = s_q.mod_s1;

    // Registered ack and read data, one wait cycle per access
    s_d.ack = bus_req && !s_q.ack;
    s_d.dat = 8'h00;
    if (wb_adr_i == OFS_CONTROL_ONE) begin
      s_d.dat = {s_q.eoc, s_q.st, s_q.sel, 4'h0};
    end else if (wb_adr_i == OFS_SEQUENCE_CONFIG) begin
      s_d.dat = {s_q.seq_ref, s_q.seq_dec, s_q.sch_rd};
    end else if (wb_adr_i == OFS_EXTRA_CONFIG) begin
      s_d.dat = {s_q.x_ref, s_q.x_dec, s_q.x_ch};
    end else if (wb_adr_i == OFS_INPUT_ENABLE) begin
      s_d.dat = s_q.ain_en;
    end else if (wb_adr_i == OFS_RESULT_LOW) begin
      s_d.dat = {s_q.res[5:0], 2'b00};
    end else if (wb_adr_i == OFS_RESULT_HIGH) begin
      s_d.dat = s_q.res[13:6];
    end

    // Register writes; unmapped addresses are acknowledged and ignored
    if (bus_wr) begin
      if (wb_adr_i == OFS_CONTROL_ONE) begin
        s_d.sel = wdat[CTL_SEL_LSB +: 2];
        if (wdat[CTL_START_BIT]) s_d.st = 1'b1;
      end else if (wb_adr_i == OFS_SEQUENCE_CONFIG) begin
        s_d.seq_ref = wdat[CFG_REF_LSB +: 2];
        s_d.seq_dec = wdat[CFG_DEC_LSB +: 2];
        s_d.sch_wr  = wdat[CFG_CH_LSB +: 4];
        s_d.sch_rd  = wdat[CFG_CH_LSB +: 4];
      end else if (wb_adr_i == OFS_EXTRA_CONFIG) begin
        s_d.x_ref  = wdat[CFG_REF_LSB +: 2];
        s_d.x_dec  = wdat[CFG_DEC_LSB +: 2];
        s_d.x_ch   = wdat[CFG_CH_LSB +: 4];
        s_d.x_pend = 1'b1;
      end else if (wb_adr_i == OFS_INPUT_ENABLE) begin
        s_d.ain_en = wdat;
      end
    end

    // Done flag: reading the high byte clears, a completing conversion wins
    if (bus_rd && wb_adr_i == OFS_RESULT_HIGH) s_d.eoc = 1'b0;
    if (cv_done) begin
      s_d.eoc = 1'b1;
      s_d.res = cv_res;
    end

    // Start event per source; while converting none is seen
    case (s_q.sel)
      SEL_EXT_PIN:    trigger = s_q.trig_s2 && !s_q.trig_s3;
      SEL_FULL_SPEED: trigger = 1'b1;
      SEL_TIMER:      trigger = timer_compare_event;
      default:        trigger = s_q.st;
    endcase

    case (s_q.state)
      SQ_IDLE: begin
        if (s_q.x_pend) begin
          s_d.x_pend = 1'b0;
          s_d.state  = SQ_EXTRA;
          s_d.go     = 1'b1;
          s_d.go_dec = s_q.x_dec;
          s_d.cur_ch = s_q.x_ch;
        end else if (trigger && !cv_busy) begin
          pick = next_ch(seq_first(s_q.sch_wr), s_q.sch_wr, s_q.ain_en);
          if (pick[4]) begin
            s_d.state  = SQ_SEQ;
            s_d.go     = 1'b1;
            s_d.go_dec = s_q.seq_dec;
            s_d.cur_ch = pick[3:0];
          end else begin
            s_d.st = 1'b0;
          end
        end
      end
      SQ_SEQ: begin
        if (cv_done) begin
          s_d.dma_any = 1'b1;
          if (s_q.cur_ch < CH_FIRST_DIFF) s_d.dma_ch[s_q.cur_ch[2:0]] = 1'b1;
          s_d.sch_rd = (s_q.sch_wr < CH_GROUP_LAST) ? s_q.cur_ch + 4'h1 : s_q.cur_ch;
          pick = next_ch({1'b0, s_q.cur_ch} + 5'h01, s_q.sch_wr, s_q.ain_en);
          if (pick[4]) begin
            s_d.go     = 1'b1;
            s_d.go_dec = s_q.seq_dec;
            s_d.cur_ch = pick[3:0];
          end else if (s_q.x_pend || s_d.x_pend) begin
            s_d.st     = 1'b0;
            s_d.x_pend = 1'b0;
            s_d.state  = SQ_EXTRA;
            s_d.go     = 1'b1;
            s_d.go_dec = s_d.x_dec;
            s_d.cur_ch = s_d.x_ch;
          end else begin
            s_d.st    = 1'b0;
            s_d.state = SQ_IDLE;
          end
        end
      end
      SQ_EXTRA: begin
        if (cv_done) begin
          s_d.irq   = 1'b1;
          s_d.state = SQ_IDLE;
        end
      end
      default: s_d.state = SQ_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= SEQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Reference follows the conversion in flight; changing it mid-way is unsafe
  assign mux_channel             = s_q.cur_ch;
  assign mux_reference           = (s_q.state == SQ_EXTRA) ? s_q.x_ref : s_q.seq_ref;
  assign wb_ack_o                = s_q.ack;
  assign wb_dat_o                = {24'h000000, s_q.dat};
  assign per_channel_dma_trigger = s_q.dma_ch;
  assign any_channel_dma_trigger = s_q.dma_any;
  assign conversion_irq          = s_q.irq;
endmodule

// ==== test/adsq_sequencer_assertions.sv ====
// Port-level assertions of the converter sequencer
module adsq_sequencer_checker import adsq_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        converter_clk,
  input wire logic [7:0]  per_channel_dma_trigger,
  input wire logic        any_channel_dma_trigger,
  input wire logic        conversion_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  logic [9:0] gap_q;
  logic       end_w;
  assign end_w = any_channel_dma_trigger | conversion_irq;
  // Saturates so a long idle spell never wraps into a false short gap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 10'h3FF;
    else if (end_w) gap_q <= 10'h000;
    else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
  end
  sequence cclk_high_s;
    converter_clk [*3];
  endsequence
  sequence cclk_low_s;
    !converter_clk [*3];
  endsequence
  sequence cclk_period_s;
    cclk_high_s ##1 cclk_low_s ##1 converter_clk;
  endsequence
  ////////////////////////////////////////
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  cclk_shape_a: assert property ($rose(converter_clk) |-> cclk_period_s)
    else $error("converter clock not divide by six");
  irq_pulse_a: assert property (conversion_irq |=> !conversion_irq)
    else $error("irq longer than one cycle");
  irq_no_dma_a: assert property (conversion_irq |-> !any_channel_dma_trigger)
    else $error("dma trigger with extra conversion");
  chan_any_a: assert property (|per_channel_dma_trigger |-> any_channel_dma_trigger)
    else $error("channel trigger without any-channel trigger");
  chan_single_a: assert property ($onehot0(per_channel_dma_trigger))
    else $error("several channel triggers at once");
  end_gap_a: assert property (end_w |-> gap_q >= 10'h1DF)
    else $error("conversion shorter than settle plus filter");
endmodule
bind adsq_sequencer adsq_sequencer_checker u_chk (
  .core_clk                (core_clk),
  .rst_n                   (rst_n),
  .wb_cyc_i                (wb_cyc_i),
  .wb_stb_i                (wb_stb_i),
  .wb_ack_o                (wb_ack_o),
  .wb_dat_o                (wb_dat_o),
  .converter_clk           (converter_clk),
  .per_channel_dma_trigger (per_channel_dma_trigger),
  .any_channel_dma_trigger (any_channel_dma_trigger),
  .conversion_irq          (conversion_irq)
);

// ==== test/adsq_far_model.sv ====
// Far side model: modulator source, DMA controller and interrupt taker
module adsq_far_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ones_mode,
  input  wire logic       clr,
  input  wire logic [7:0] per_channel_dma_trigger,
  input  wire logic       any_channel_dma_trigger,
  input  wire logic       conversion_irq,
  output logic            modulator_bit,
  output logic [7:0]      ch_mask,
  output logic [7:0]      any_cnt,
  output logic [7:0]      irq_cnt,
  output logic [9:0]      gap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] run_q;
  // Constant density gives full scale results whatever the sync delay
  assign modulator_bit = ones_mode;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n || clr) begin
      ch_mask <= 8'h00;
      any_cnt <= 8'h00;
      irq_cnt <= 8'h00;
      run_q   <= 10'h000;
      gap     <= 10'h000;
    end else begin
      ch_mask <= ch_mask | per_channel_dma_trigger;
      any_cnt <= any_cnt + {7'h00, any_channel_dma_trigger};
      irq_cnt <= irq_cnt + {7'h00, conversion_irq};
      run_q   <= any_channel_dma_trigger ? 10'h000 : run_q + 10'h001;
      if (any_channel_dma_trigger) gap <= run_q + 10'h001;
    end
  end
endmodule

// ==== test/adsq_sequencer_bench.sv ====
// Self-checking bench of the converter sequencer
module adsq_sequencer_bench import adsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, cyc, stb, we, pin, tmr, ones, clr;
  logic [7:0] adr, ch_mask, any_cnt, irq_cnt, per_tr;
  logic [3:0] sel, mux_ch;
  logic [31:0] dat, dat_o;
  logic [9:0] gap;
  logic [1:0] mux_ref;
  logic ack, mod_bit, any_tr, irq;
  int n_mismatch, n_tests;
  adsq_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .external_trigger_pin(pin), .timer_compare_event(tmr),
    .modulator_bit(mod_bit), .converter_clk(), .mux_channel(mux_ch), .mux_reference(mux_ref),
    .per_channel_dma_trigger(per_tr), .any_channel_dma_trigger(any_tr), .conversion_irq(irq));
  adsq_far_model u_far (.core_clk(core_clk), .rst_n(rst_n), .ones_mode(ones), .clr(clr),
    .per_channel_dma_trigger(per_tr), .any_channel_dma_trigger(any_tr), .conversion_irq(irq),
    .modulator_bit(mod_bit), .ch_mask(ch_mask), .any_cnt(any_cnt), .irq_cnt(irq_cnt), .gap(gap));
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int g;
    @(posedge core_clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, 24'h000000, d};
    g = 0;
    // Ack is looked at mid-cycle, away from the edge that launches it
    do begin
      @(negedge core_clk);
      g++;
    end while (ack !== 1'b1 && g < 50);
    if (ack !== 1'b1) n_mismatch++;
    q = dat_o[7:0];
    @(posedge core_clk);
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  // Bounded wait on a far side counter, then judge its value
  task automatic wait_cnt(input logic use_irq, input logic [7:0] n, output int g);
    g = 0;
    while ((use_irq ? irq_cnt : any_cnt) !== n && g < 4000) begin
      @(negedge core_clk);
      g++;
    end
    chk({8'h00, use_irq ? irq_cnt : any_cnt}, {8'h00, n});
  endtask
  task automatic clr_cnt();
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rc(OFS_CONTROL_ONE, 8'h30);
    rc(OFS_SEQUENCE_CONFIG, 8'h00);
    rc(OFS_EXTRA_CONFIG, 8'h00);
    rc(OFS_RESULT_HIGH, 8'h00);
    wr(8'h20, 8'hFF);
    rc(8'h20, 8'h00);
    sel <= 4'h0;
    wr(OFS_INPUT_ENABLE, 8'hFF);
    sel <= 4'hF;
    rc(OFS_INPUT_ENABLE, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_sequence();
    int g;
    ones <= 1'b1;
    wr(OFS_INPUT_ENABLE, 8'h0B);
    wr(OFS_SEQUENCE_CONFIG, 8'h03);
    clr_cnt();
    wr(OFS_CONTROL_ONE, 8'h70);
    wait_cnt(1'b0, 8'h01, g);
    wr(OFS_CONTROL_ONE, 8'h70);
    wait_cnt(1'b0, 8'h02, g);
    chk({15'h0000, gap >= 10'h1E0 && gap <= 10'h1EF}, 16'h0001);
    repeat (1100) @(posedge core_clk);
    chk({8'h00, any_cnt}, 16'h0003);
    chk({8'h00, ch_mask}, 16'h000B);
    chk({8'h00, irq_cnt}, 16'h0000);
    rc(OFS_CONTROL_ONE, 8'hB0);
    rc(OFS_SEQUENCE_CONFIG, 8'h04);
    rc(OFS_RESULT_LOW, 8'hFC);
    rc(OFS_CONTROL_ONE, 8'hB0);
    rc(OFS_RESULT_HIGH, 8'h7F);
    rc(OFS_CONTROL_ONE, 8'h30);
    $display("test sequence done");
  endtask
  task automatic t_extra();
    int g;
    ones <= 1'b0;
    wr(OFS_INPUT_ENABLE, 8'hFF);
    clr_cnt();
    wr(OFS_EXTRA_CONFIG, 8'h58);
    repeat (29) @(posedge core_clk);
    chk({12'h000, mux_ch}, 16'h0008);
    chk({14'h0000, mux_ref}, 16'h0001);
    wait_cnt(1'b1, 8'h01, g);
    chk({15'h0000, g >= 834 && g <= 850}, 16'h0001);
    chk({8'h00, any_cnt}, 16'h0000);
    rc(OFS_RESULT_LOW, 8'h00);
    rc(OFS_RESULT_HIGH, 8'h80);
    wr(OFS_EXTRA_CONFIG, 8'h00);
    wait_cnt(1'b1, 8'h02, g);
    rc(OFS_RESULT_HIGH, 8'h00);
    $display("test extra done");
  endtask
  task automatic t_order();
    int g;
    ones <= 1'b1;
    wr(OFS_INPUT_ENABLE, 8'h03);
    wr(OFS_SEQUENCE_CONFIG, 8'h09);
    clr_cnt();
    wr(OFS_CONTROL_ONE, 8'h70);
    repeat (20) @(posedge core_clk);
    wr(OFS_EXTRA_CONFIG, 8'h0D);
    wait_cnt(1'b1, 8'h01, g);
    chk({8'h00, any_cnt}, 16'h0001);
    chk({8'h00, ch_mask}, 16'h0000);
    rc(OFS_SEQUENCE_CONFIG, 8'h09);
    wr(OFS_SEQUENCE_CONFIG, 8'h0D);
    wr(OFS_CONTROL_ONE, 8'h70);
    wait_cnt(1'b0, 8'h02, g);
    repeat (600) @(posedge core_clk);
    chk({8'h00, any_cnt}, 16'h0002);
    rc(OFS_SEQUENCE_CONFIG, 8'h0D);
    $display("test order done");
  endtask
  task automatic t_sources();
    int g;
    wr(OFS_INPUT_ENABLE, 8'h01);
    wr(OFS_SEQUENCE_CONFIG, 8'h00);
    clr_cnt();
    wr(OFS_CONTROL_ONE, 8'h00);
    pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    pin <= 1'b0;
    wait_cnt(1'b0, 8'h01, g);
    wr(OFS_CONTROL_ONE, 8'h20);
    tmr <= 1'b1;
    @(posedge core_clk);
    tmr <= 1'b0;
    wait_cnt(1'b0, 8'h02, g);
    wr(OFS_CONTROL_ONE, 8'h70);
    wr(OFS_CONTROL_ONE, 8'h10);
    wait_cnt(1'b0, 8'h04, g);
    wr(OFS_CONTROL_ONE, 8'h30);
    repeat (600) @(posedge core_clk);
    chk({8'h00, ch_mask}, 16'h0001);
    $display("test sources done");
  endtask
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {core_clk, rst_n, cyc, stb, we, pin, tmr, ones, clr} = 9'h000;
    {adr, sel, dat} = {8'h00, 4'hF, 32'h00000000};
    n_mismatch = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_sequence();
    t_extra();
    t_order();
    t_sources();
    report_and_stop();
  end
  // Whole run needs about 8000 cycles; over seven times that means a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
